// File: src/cspu_defines.vh
// Offsets, field positions, reset values and timing counts of the power-up sequencer
`ifndef CSPU_DEFINES_VH
`define CSPU_DEFINES_VH

// ****************************
// Register offsets
// ****************************
`define CSPU_ADDR_MODE_CTRL 16'h0100
`define CSPU_ADDR_SOFT_RESET 16'h0103
`define CSPU_ADDR_REF_FREQ_HI 16'h0136
`define CSPU_ADDR_REF_FREQ_LO 16'h0137
`define CSPU_ADDR_INTEG_HI 16'h0202
`define CSPU_ADDR_INTEG_LO 16'h0203
`define CSPU_ADDR_STATUS 16'h0018

// ****************************
// Field values and positions
// ****************************
`define CSPU_MODE_STREAM 8'h01
`define CSPU_MODE_STANDBY 8'h00
`define CSPU_SOFT_RESET_CMD 8'h01
`define CSPU_STAT_LOCK_BIT 0
`define CSPU_STAT_STREAM_BIT 1
`define CSPU_STAT_REF_BIT 2

// ****************************
// Reset values
// ****************************
`define CSPU_MODE_RESET 8'h00
`define CSPU_REF_FREQ_RESET 16'h0000
`define CSPU_INTEG_RESET 16'h0010

// ****************************
// Reference clock range and timing
// ****************************
`define CSPU_REF_MIN_MHZ 16'h0006
`define CSPU_REF_MAX_MHZ 16'h001b
`define CSPU_CLK_MHZ 100
`define CSPU_LOCK_TIME_US 1000
`define CSPU_FIXED_DELAY_US 1
`define CSPU_LINE_CYCLES 100
`define CSPU_REF_IDLE_CYCLES 8'h20

`endif

// File: src/cspu_timer.v
// Loadable down counter giving a one-cycle pulse when it expires
`timescale 1ns/1ps
module cspu_timer #(
    parameter W = 32
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire clear_i,
    input wire load_i,
    input wire [W-1:0] load_val_i,
    output reg done_o,
    output wire busy_o
);

    reg [W-1:0] count_reg;
    reg running_reg;

    assign busy_o = running_reg;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= {W{1'b0}};
            running_reg <= 1'b0;
            done_o <= 1'b0;
        end else if (clear_i) begin
            count_reg <= {W{1'b0}};
            running_reg <= 1'b0;
            done_o <= 1'b0;
        end else if (load_i) begin
            count_reg <= load_val_i;
            running_reg <= 1'b1;
            done_o <= 1'b0;
        end else if (running_reg) begin
            // Expiry counted as load value cycles, never less than one
            if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
                running_reg <= 1'b0;
                done_o <= 1'b1;
            end else begin
                count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
                done_o <= 1'b0;
            end
        end else begin
            done_o <= 1'b0;
        end
    end

endmodule // cspu_timer

// File: src/cspu_sequencer.v
// Power-up, clock bring-up and streaming sequencer of the image sensor device
`timescale 1ns/1ps
`include "cspu_defines.vh"
module cspu_sequencer #(
    parameter LOCK_CYCLES = `CSPU_LOCK_TIME_US * `CSPU_CLK_MHZ,
    parameter FIXED_CYCLES = `CSPU_FIXED_DELAY_US * `CSPU_CLK_MHZ,
    parameter LINE_CYCLES = `CSPU_LINE_CYCLES
) (
    input wire SYS_CLK_I,
    input wire RST_N_I,
    input wire SHUTDOWN_N_I,
    input wire REF_CLK_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [15:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    output reg [7:0] REG_RDATA_O,
    output reg REG_RVALID_O,
    output wire PORT_READY_O,
    output reg PLL_LOCKED_O,
    output reg STREAMING_O,
    output reg FRAME_START_O
);

    // ****************************
    // States
    // ****************************
    localparam [1:0] ST_HW_STBY = 2'b00;
    localparam [1:0] ST_SW_STBY = 2'b01;
    localparam [1:0] ST_FRAME_WAIT = 2'b10;
    localparam [1:0] ST_STREAM = 2'b11;

    function hit;
        input [15:0] addr;
        input [15:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] mode_reg;
    reg [15:0] ref_freq_reg;
    reg [15:0] integ_reg;
    reg ref_d_reg;
    reg [7:0] ref_idle_reg;
    reg ref_active_reg;
    reg [31:0] lock_cnt_reg;

    wire port_on;
    wire wr_ok;
    wire soft_reset;
    wire ref_edge;
    wire freq_ok;
    wire freq_write;
    wire pll_enable;
    wire frame_done;
    wire [31:0] frame_delay;
    wire [31:0] integ_cycles;

    // ****************************
    // Control port gating
    // ****************************
    // Port is dead in hardware standby; no write can land there
    assign port_on = SHUTDOWN_N_I;
    assign PORT_READY_O = port_on;
    assign wr_ok = REG_WR_I & port_on;
    assign soft_reset = wr_ok & hit(REG_ADDR_I, `CSPU_ADDR_SOFT_RESET)
        & (REG_WDATA_I == `CSPU_SOFT_RESET_CMD);
    assign freq_write = wr_ok & (hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_HI)
        | hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_LO));

    // ****************************
    // Register map
    // ****************************
    always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_reg <= `CSPU_MODE_RESET;
            ref_freq_reg <= `CSPU_REF_FREQ_RESET;
            integ_reg <= `CSPU_INTEG_RESET;
        end else if (!SHUTDOWN_N_I || soft_reset) begin
            mode_reg <= `CSPU_MODE_RESET;
            ref_freq_reg <= `CSPU_REF_FREQ_RESET;
            integ_reg <= `CSPU_INTEG_RESET;
        end else if (wr_ok) begin
            if (hit(REG_ADDR_I, `CSPU_ADDR_MODE_CTRL)) begin
                mode_reg <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_HI)) begin
                ref_freq_reg[15:8] <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_LO)) begin
                ref_freq_reg[7:0] <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `CSPU_ADDR_INTEG_HI)) begin
                integ_reg[15:8] <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `CSPU_ADDR_INTEG_LO)) begin
                integ_reg[7:0] <= REG_WDATA_I;
            end
        end
    end

    always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 8'h00;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I & port_on;
            if (REG_RD_I && port_on) begin
                if (hit(REG_ADDR_I, `CSPU_ADDR_MODE_CTRL)) begin
                    REG_RDATA_O <= mode_reg;
                end else if (hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_HI)) begin
                    REG_RDATA_O <= ref_freq_reg[15:8];
                end else if (hit(REG_ADDR_I, `CSPU_ADDR_REF_FREQ_LO)) begin
                    REG_RDATA_O <= ref_freq_reg[7:0];
                end else if (hit(REG_ADDR_I, `CSPU_ADDR_INTEG_HI)) begin
                    REG_RDATA_O <= integ_reg[15:8];
                end else if (hit(REG_ADDR_I, `CSPU_ADDR_INTEG_LO)) begin
                    REG_RDATA_O <= integ_reg[7:0];
                end else if (hit(REG_ADDR_I, `CSPU_ADDR_STATUS)) begin
                    REG_RDATA_O <= {5'h00, ref_active_reg, STREAMING_O, PLL_LOCKED_O};
                end else begin
                    REG_RDATA_O <= 8'h00;
                end
            end
        end
    end

    // ****************************
    // Reference clock watch
    // ****************************
    // Reference may be parked low until standby or run free; lock counts until 32 cycles pass without a rising edge
    assign ref_edge = REF_CLK_I & ~ref_d_reg;

    always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ref_d_reg <= 1'b0;
            ref_idle_reg <= 8'h00;
            ref_active_reg <= 1'b0;
        end else begin
            ref_d_reg <= REF_CLK_I;
            if (ref_edge) begin
                ref_idle_reg <= 8'h00;
                ref_active_reg <= 1'b1;
            end else if (ref_idle_reg >= `CSPU_REF_IDLE_CYCLES) begin
                ref_active_reg <= 1'b0;
            end else begin
                ref_idle_reg <= ref_idle_reg + 8'h01;
            end
        end
    end

    // ****************************
    // PLL lock model
    // ****************************
    assign freq_ok = (ref_freq_reg >= `CSPU_REF_MIN_MHZ) && (ref_freq_reg <= `CSPU_REF_MAX_MHZ);
    assign pll_enable = SHUTDOWN_N_I & ref_active_reg & freq_ok;

    always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lock_cnt_reg <= 32'h0;
            PLL_LOCKED_O <= 1'b0;
        end else if (!pll_enable || freq_write || soft_reset) begin
            // Retuning the reference restarts acquisition
            lock_cnt_reg <= 32'h0;
            PLL_LOCKED_O <= 1'b0;
        end else begin
            if (lock_cnt_reg >= LOCK_CYCLES - 1) begin
                PLL_LOCKED_O <= 1'b1;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 32'h1;
            end
        end
    end

    // ****************************
    // First frame delay
    // ****************************
    assign integ_cycles = {16'h0000, integ_reg} * LINE_CYCLES;
    assign frame_delay = FIXED_CYCLES + integ_cycles;

    cspu_timer #(
        .W(32)
    ) u_frame_timer (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        // Cleared from the next state, so the load edge is not swallowed by the clear
        .clear_i(state_next != ST_FRAME_WAIT),
        .load_i((state_reg == ST_SW_STBY) && (state_next == ST_FRAME_WAIT)),
        .load_val_i(frame_delay),
        .done_o(frame_done),
        .busy_o()
    );

    // ****************************
    // Mode state machine
    // ****************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_HW_STBY: begin
                if (SHUTDOWN_N_I) begin
                    state_next = ST_SW_STBY;
                end
            end
            ST_SW_STBY: begin
                // Streaming waits for lock, so a premature mode write just stays pending
                if (mode_reg == `CSPU_MODE_STREAM && PLL_LOCKED_O) begin
                    state_next = ST_FRAME_WAIT;
                end
            end
            ST_FRAME_WAIT: begin
                if (mode_reg != `CSPU_MODE_STREAM || !PLL_LOCKED_O) begin
                    state_next = ST_SW_STBY;
                end else if (frame_done) begin
                    state_next = ST_STREAM;
                end
            end
            ST_STREAM: begin
                if (mode_reg != `CSPU_MODE_STREAM || !PLL_LOCKED_O) begin
                    state_next = ST_SW_STBY;
                end
            end
            default: begin
                state_next = ST_HW_STBY;
            end
        endcase
        if (!SHUTDOWN_N_I) begin
            state_next = ST_HW_STBY;
        end else if (soft_reset && state_reg != ST_HW_STBY) begin
            state_next = ST_SW_STBY;
        end
    end

    always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_HW_STBY;
            STREAMING_O <= 1'b0;
            FRAME_START_O <= 1'b0;
        end else begin
            state_reg <= state_next;
            STREAMING_O <= (state_next == ST_STREAM);
            FRAME_START_O <= (state_reg == ST_FRAME_WAIT) && (state_next == ST_STREAM);
        end
    end

endmodule // cspu_sequencer

// File: verif/cspu_properties.sv
// Port checks of the power-up sequencer
`timescale 1ns/1ps
module cspu_props (
    input wire SYS_CLK_I,
    input wire RST_N_I,
    input wire SHUTDOWN_N_I,
    input wire REF_CLK_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [15:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    input wire [7:0] REG_RDATA_O,
    input wire REG_RVALID_O,
    input wire PORT_READY_O,
    input wire PLL_LOCKED_O,
    input wire STREAMING_O,
    input wire FRAME_START_O
);
// ****
// Reference idle count, margin above the 32-cycle detector
// ****
reg ref_prev_reg;
reg [5:0] idle_reg;
wire wr_ok = REG_WR_I && SHUTDOWN_N_I;
always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        ref_prev_reg <= 1'b0;
        idle_reg <= 6'h00;
    end else begin
        ref_prev_reg <= REF_CLK_I;
        if (REF_CLK_I != ref_prev_reg) idle_reg <= 6'h00;
        else if (idle_reg != 6'h3f) idle_reg <= idle_reg + 6'h01;
    end
end
default clocking cb @(posedge SYS_CLK_I); endclocking
default disable iff (!RST_N_I);
sequence pulse_seq;
    FRAME_START_O ##1 !FRAME_START_O;
endsequence
ready_tracks_a: assert property (PORT_READY_O == SHUTDOWN_N_I)
    else $error("ready differs");
read_answer_a: assert property (REG_RD_I && SHUTDOWN_N_I |=> REG_RVALID_O)
    else $error("no read answer");
read_cause_a: assert property (REG_RVALID_O |-> $past(REG_RD_I && SHUTDOWN_N_I))
    else $error("answer without read");
shut_clears_a: assert property (!SHUTDOWN_N_I |=> !PLL_LOCKED_O && !STREAMING_O)
    else $error("standby kept state");
freq_unlocks_a: assert property (wr_ok && REG_ADDR_I[15:1] == 15'h009b |=> !PLL_LOCKED_O)
    else $error("freq write kept lock");
soft_reset_a: assert property (wr_ok && REG_ADDR_I == 16'h0103 && REG_WDATA_I == 8'h01 |=> !STREAMING_O)
    else $error("soft reset kept stream");
// Mode register lands one edge, the state follows on the next
standby_write_a: assert property (wr_ok && REG_ADDR_I == 16'h0100 && REG_WDATA_I == 8'h00 |-> ##2 !STREAMING_O)
    else $error("standby write kept stream");
ref_stop_a: assert property (idle_reg > 6'd40 |-> !PLL_LOCKED_O)
    else $error("lock without reference");
frame_pulse_a: assert property ($rose(STREAMING_O) |-> pulse_seq)
    else $error("bad frame pulse");
stream_entry_a: assert property ($rose(STREAMING_O) |-> PLL_LOCKED_O)
    else $error("stream without lock");
endmodule // cspu_props
bind cspu_sequencer cspu_props u_props (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .SHUTDOWN_N_I(SHUTDOWN_N_I),
    .REF_CLK_I(REF_CLK_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
    .PORT_READY_O(PORT_READY_O), .PLL_LOCKED_O(PLL_LOCKED_O), .STREAMING_O(STREAMING_O),
    .FRAME_START_O(FRAME_START_O));

// File: verif/cspu_host.sv
// Host model: supplies, shutdown_n, reference clock, port wait
`timescale 1ns/1ps
module cspu_host (
    input wire clk_i,
    input wire rst_n_i,
    input wire wake_i,
    input wire ref_en_i,
    output reg shutdown_n_o,
    output reg ref_clk_o,
    output reg ready_o
);
reg digital_supply, analog_supply;
reg [1:0] div_reg;
integer edges;
always @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        {digital_supply, analog_supply, shutdown_n_o, ref_clk_o, ready_o, div_reg} <= 7'h00;
        edges <= 0;
    end else begin
        analog_supply <= 1'b1;
        digital_supply <= analog_supply;
        shutdown_n_o <= wake_i && digital_supply && analog_supply;
        div_reg <= div_reg + 2'h1;
        // 12.5 MHz; free running unless the bench stops it, which holds its last level
        if (ref_en_i && div_reg == 2'h3) ref_clk_o <= ~ref_clk_o;
        if (!shutdown_n_o) edges <= 0;
        else if (ref_en_i && div_reg == 2'h3 && !ref_clk_o) edges <= edges + 1;
        ready_o <= shutdown_n_o && ref_en_i && edges >= 2400;
    end
end
endmodule // cspu_host

// File: verif/camera_sensor_powerup_sequencer_tb.sv
// Self-checking bench of the power-up sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("mismatch %0t: %h", $time, a); end end
module camera_sensor_powerup_sequencer_tb;
localparam LK = 50;
localparam FX = 20;
localparam LN = 10;
reg sys_clk = 0, rst_n = 0, wake = 0, ref_en = 1, wr = 0, rd = 0;
reg [15:0] addr = 16'h0000;
reg [7:0] wdata = 8'h00;
wire shut_n, ref_clk, host_ok, rvalid, ready, locked, strm, fs;
wire [7:0] rdata;
integer errors = 0, total_checks = 0, seed = 32'h5772c9d0, n, i, v;
// Model map: five writable bytes, then soft reset and an unmapped byte, both read 0
reg [7:0] exp_mem [0:6];
int al[7] = '{16'h0100, 16'h0136, 16'h0137, 16'h0202, 16'h0203, 16'h0103, 16'h0400};
int fq[4] = '{5, 6, 27, 28};
always #5 sys_clk = ~sys_clk;
cspu_host u_host (.clk_i(sys_clk), .rst_n_i(rst_n), .wake_i(wake), .ref_en_i(ref_en),
    .shutdown_n_o(shut_n), .ref_clk_o(ref_clk), .ready_o(host_ok));
cspu_sequencer #(.LOCK_CYCLES(LK), .FIXED_CYCLES(FX), .LINE_CYCLES(LN)) u_dut (.SYS_CLK_I(sys_clk),
    .RST_N_I(rst_n), .SHUTDOWN_N_I(shut_n), .REF_CLK_I(ref_clk), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .PORT_READY_O(ready), .PLL_LOCKED_O(locked), .STREAMING_O(strm), .FRAME_START_O(fs));
// ****
// Model and bus tasks
// ****
task wrap_up;
    if (errors == 0 && total_checks > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask
task timeout;
    errors++;
    $display("mismatch %0t: wait bound", $time);
    wrap_up();
endtask
task mdl_reset;
    for (int k = 0; k < 7; k++) exp_mem[k] = 8'h00;
    exp_mem[4] = 8'h10;
endtask
task wr_reg(input [15:0] a, input [7:0] d);
    @(negedge sys_clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    wr = 0;
    if (a == 16'h0103 && d == 8'h01) mdl_reset();
    else for (int k = 0; k < 5; k++) if (a == al[k]) exp_mem[k] = d;
endtask
task rd_chk(input [15:0] a, input [7:0] e);
    @(negedge sys_clk);
    {rd, addr} = {1'b1, a};
    @(negedge sys_clk);
    rd = 0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
endtask
task chk_map;
    for (int k = 0; k < 7; k++) rd_chk(al[k][15:0], exp_mem[k]);
endtask
task rd_off;
    @(negedge sys_clk);
    {rd, addr} = {1'b1, 16'h0018};
    @(negedge sys_clk);
    rd = 0;
    `CHK(rvalid, 1'b0)
    `CHK(ready, 1'b0)
endtask
task wake_up;
    wake <= 1;
    for (n = 0; host_ok !== 1'b1 && n < 30000; n++) @(negedge sys_clk);
    if (n >= 30000) timeout();
    mdl_reset();
endtask
task lock_wait(input bit e);
    repeat (2) @(negedge sys_clk);
    for (n = 2; locked !== 1'b1 && n < LK + 20; n++) @(negedge sys_clk);
    if (e && n >= LK + 20) timeout();
    if (e) `CHK(n >= LK - 1 && n <= LK + 4, 1'b1)
    else `CHK(locked, 1'b0)
endtask
task frame_wait(input int ln);
    for (n = 0; fs !== 1'b1 && n < 400; n++) @(negedge sys_clk);
    if (n >= 400) timeout();
    `CHK(n >= FX + ln * LN && n <= FX + ln * LN + 8, 1'b1)
    `CHK(strm, 1'b1)
endtask
// ****
// Scenarios
// ****
initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    rd_off();
    wake_up();
    wr_reg(16'h0400, 8'h55);
    wr_reg(16'h0018, 8'hff);
    chk_map();
    rd_chk(16'h0018, 8'h04);
    for (i = 0; i < 5; i++) begin
        v = i < 4 ? fq[i] : 6 + {$random(seed)} % 22;
        wr_reg(16'h0137, v[7:0]);
        lock_wait(v >= 6 && v <= 27);
    end
    v = 1 + {$random(seed)} % 3;
    wr_reg(16'h0203, v[7:0]);
    wr_reg(16'h0100, 8'h01);
    frame_wait(v);
    rd_chk(16'h0018, 8'h07);
    wr_reg(16'h0100, 8'h00);
    @(negedge sys_clk);
    `CHK(strm, 1'b0)
    v = $random(seed);
    wr_reg(16'h0202, v[7:0]);
    wr_reg(16'h0103, 8'h01);
    chk_map();
    rd_chk(16'h0018, 8'h04);
    wr_reg(16'h0100, 8'h01);
    repeat (30) @(negedge sys_clk);
    `CHK(strm, 1'b0)
    wr_reg(16'h0137, 8'h0c);
    lock_wait(1);
    frame_wait(16);
    wake <= 0;
    ref_en <= 0;
    repeat (2) @(negedge sys_clk);
    `CHK({locked, strm}, 2'b00)
    rd_off();
    // Reference parked low, then started in software standby
    wake <= 1;
    repeat (20) @(negedge sys_clk);
    ref_en <= 1;
    wake_up();
    chk_map();
    wr_reg(16'h0137, 8'h0c);
    lock_wait(1);
    ref_en <= 0;
    repeat (45) @(negedge sys_clk);
    `CHK(locked, 1'b0)
    wrap_up();
end
initial begin
    #1000000;
    timeout();
end
endmodule // camera_sensor_powerup_sequencer_tb
